// ===== hw/bntr_pkg.sv
// shared constants, types and calendar helpers of the timekeeping ram
package bntr_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SEC_PERIOD_S = 1;
    localparam int unsigned SEC_CYCLES = CLK_HZ * SEC_PERIOD_S;
    localparam int unsigned FT_HZ = 512;
    // half period of the test square wave, rounded down
    localparam int unsigned FT_HALF_CYCLES = CLK_HZ / (2 * FT_HZ);
    localparam int unsigned SEC_CNT_W = 26;
    localparam int unsigned FT_CNT_W = 16;

    // ****************************************
    // memory geometry and clock register map
    // ****************************************
    localparam int unsigned ADDR_W = 11;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MEM_DEPTH = 2048;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 11'h7F8;
    localparam logic [ADDR_W-1:0] ADDR_SEC = 11'h7F9;
    localparam logic [ADDR_W-1:0] ADDR_MIN = 11'h7FA;
    localparam logic [ADDR_W-1:0] ADDR_HOUR = 11'h7FB;
    localparam logic [ADDR_W-1:0] ADDR_DAY = 11'h7FC;
    localparam logic [ADDR_W-1:0] ADDR_DATE = 11'h7FD;
    localparam logic [ADDR_W-1:0] ADDR_MONTH = 11'h7FE;
    localparam logic [ADDR_W-1:0] ADDR_YEAR = 11'h7FF;

    // ****************************************
    // field positions and masks
    // ****************************************
    localparam int unsigned CTRL_W_BIT = 7;
    localparam int unsigned CTRL_R_BIT = 6;
    localparam int unsigned SEC_OSC_BIT = 7;
    localparam int unsigned DAY_FT_BIT = 6;
    localparam logic [7:0] MASK_SEC = 8'h7F;
    localparam logic [7:0] MASK_MIN = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_DAY = 8'h07;
    localparam logic [7:0] MASK_DATE = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_YEAR = 8'hFF;

    // ****************************************
    // bcd limits
    // ****************************************
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] MIN_MAX = 8'h59;
    localparam logic [7:0] HOUR_MAX = 8'h23;
    localparam logic [7:0] DAY_MAX = 8'h07;
    localparam logic [7:0] MONTH_MAX = 8'h12;
    localparam logic [7:0] YEAR_MAX = 8'h99;

    // ****************************************
    // carriers and state
    // ****************************************
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } bntr_time_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [DATA_W-1:0] dq;
    } bntr_bus_t;

    typedef struct packed {
        bntr_bus_t bus_m;
        bntr_bus_t bus_s;
        logic pf_m;
        logic pf_s;
        logic ctl_w;
        logic ctl_r;
        logic osc_stop;
        logic ft;
        bntr_time_t cnt;
        bntr_time_t user;
        logic [SEC_CNT_W-1:0] pre;
        logic [FT_CNT_W-1:0] ftc;
        logic ft_tog;
        logic wr_pend;
        logic [ADDR_W-1:0] wa;
        logic [DATA_W-1:0] wd;
        logic [DATA_W-1:0] rd;
        logic drive;
    } bntr_state_t;

    // ****************************************
    // reset values
    // ****************************************
    localparam bntr_time_t TIME_RESET = '{year: 8'h00, month: 8'h01, date: 8'h01,
        day: 8'h01, hour: 8'h00, min: 8'h00, sec: 8'h00};
    localparam bntr_bus_t BUS_IDLE = '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
        dq: '0};
    localparam bntr_state_t ST_RESET = '{bus_m: BUS_IDLE, bus_s: BUS_IDLE,
        cnt: TIME_RESET, user: TIME_RESET, default: '0};

    // ****************************************
    // calendar helpers
    // ****************************************
    // one bcd step, wrapping hi to lo; msb is the carry
    function automatic logic [8:0] bntr_bcd_step(input logic [7:0] v,
        input logic [7:0] lo, input logic [7:0] hi);
        if (v >= hi) begin
            return {1'b1, lo};
        end
        if (v[3:0] >= 4'h9) begin
            return {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        return {1'b0, v[7:4], v[3:0] + 4'h1};
    endfunction

    // leap year on a two digit bcd year, 00 counted as leap
    function automatic logic bntr_leap(input logic [7:0] y);
        if (y[4]) begin
            return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    endfunction

    // last date of a bcd month
    function automatic logic [7:0] bntr_last_date(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02: return bntr_leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction

endpackage

// ===== hw/bntr_top.sv
// byte-wide nonvolatile ram with a bcd real-time clock in its top eight bytes
//
// Functional notes
// - 2048 by 8 static ram, asynchronous port
// - clock registers in top eight addresses
// - bcd time, hours in 24-hour form
// - month lengths and leap years to 2100
// - user buffer separate from running counters
// - power fail deselects, accesses ignored
// - read-halt bit freezes user buffer
// - frozen buffer holds time at halt
// - counters keep running while halted
// - after halt clears, buffer refreshes together
// - write-halt bit also freezes user buffer
// - clearing write-halt loads counters, resumes
// - chip enable high deselects, pins released
// - chip and write enables low write
// - enables low, write high, drive data
// - output enable high keeps pins released
// - seconds msb stops the timebase
// - tick-test bit toggles seconds lsb 512 Hz
`timescale 1ns/1ps
module bntr_top
    import bntr_pkg::*;
#(
    parameter int unsigned P_SEC_CYCLES = SEC_CYCLES,
    parameter int unsigned P_FT_CYCLES = FT_HALF_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    input wire bntr_bus_t bus_in,
    input wire logic power_fail,
    output logic [DATA_W-1:0] data_pins_out,
    output logic data_pins_oe_n
);

    // ****************************************
    // elaboration checks
    // ****************************************
    if (P_SEC_CYCLES < 2 || P_SEC_CYCLES >= (2 ** SEC_CNT_W)) begin : g_bad_sec
        $error("second count out of range");
    end
    if (P_FT_CYCLES < 1 || P_FT_CYCLES >= (2 ** FT_CNT_W)) begin : g_bad_ft
        $error("test toggle count out of range");
    end

    // ****************************************
    // state and decode
    // ****************************************
    bntr_state_t s;
    bntr_state_t next_s;
    logic [DATA_W-1:0] ram [MEM_DEPTH];
    logic rd_cond;
    logic wr_act;
    logic wr_commit;
    logic halted;
    logic wa_clk;
    logic ra_clk;
    logic sec_tick;
    logic ft_wrap;
    logic w_release;
    logic [DATA_W-1:0] rd_mux;

    // read and write decode on synchronised pins
    // power fail gates every access
    assign rd_cond = !s.pf_s && !s.bus_s.ce_n && s.bus_s.we_n && !s.bus_s.oe_n;
    assign wr_act = !s.pf_s && !s.bus_s.ce_n && !s.bus_s.we_n;
    assign wr_commit = s.wr_pend && !wr_act && !s.pf_s;
    // either halt bit freezes the buffer
    assign halted = s.ctl_w || s.ctl_r;
    // top eight addresses are the clock
    assign wa_clk = &s.wa[ADDR_W-1:3];
    assign ra_clk = &s.bus_s.addr[ADDR_W-1:3];
    // no tick while the timebase is stopped
    assign sec_tick = !s.osc_stop && (s.pre == SEC_CNT_W'(P_SEC_CYCLES - 1));
    assign ft_wrap = s.ftc == FT_CNT_W'(P_FT_CYCLES - 1);
    // write-halt cleared by a control write
    assign w_release = wr_commit && wa_clk && (s.wa == ADDR_CTRL) && s.ctl_w
        && !s.wd[CTRL_W_BIT];

    // advance the running counters by one second
    // bcd digits, 24-hour wrap
    function automatic bntr_time_t bntr_advance(input bntr_time_t t);
        bntr_time_t r;
        logic [8:0] st;
        r = t;
        st = bntr_bcd_step(t.sec, BCD_ZERO, SEC_MAX);
        r.sec = st[7:0];
        if (st[8]) begin
            st = bntr_bcd_step(t.min, BCD_ZERO, MIN_MAX);
            r.min = st[7:0];
            if (st[8]) begin
                st = bntr_bcd_step(t.hour, BCD_ZERO, HOUR_MAX);
                r.hour = st[7:0];
                if (st[8]) begin
                    st = bntr_bcd_step(t.day, BCD_ONE, DAY_MAX);
                    r.day = st[7:0];
                    // month length from month and year
                    st = bntr_bcd_step(t.date, BCD_ONE, bntr_last_date(t.month, t.year));
                    r.date = st[7:0];
                    if (st[8]) begin
                        st = bntr_bcd_step(t.month, BCD_ONE, MONTH_MAX);
                        r.month = st[7:0];
                        if (st[8]) begin
                            st = bntr_bcd_step(t.year, BCD_ZERO, YEAR_MAX);
                            r.year = st[7:0];
                        end
                    end
                end
            end
        end
        return r;
    endfunction

    // ****************************************
    // read multiplexer
    // ****************************************
    // control lowest, year highest
    always_comb begin
        rd_mux = ram[s.bus_s.addr];
        if (ra_clk) begin
            case (s.bus_s.addr)
                ADDR_CTRL: rd_mux = {s.ctl_w, s.ctl_r, 6'h00};
                // seconds lsb shows the test wave
                ADDR_SEC: rd_mux = {s.osc_stop, s.user.sec[6:1],
                    s.ft ? s.ft_tog : s.user.sec[0]};
                ADDR_MIN: rd_mux = s.user.min;
                ADDR_HOUR: rd_mux = s.user.hour;
                ADDR_DAY: rd_mux = {1'b0, s.ft, 3'h0, s.user.day[2:0]};
                ADDR_DATE: rd_mux = s.user.date;
                ADDR_MONTH: rd_mux = s.user.month;
                ADDR_YEAR: rd_mux = s.user.year;
                default: rd_mux = ram[s.bus_s.addr];
            endcase
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;
        // two-stage pin synchronisers
        next_s.bus_m = bus_in;
        next_s.bus_s = s.bus_m;
        next_s.pf_m = power_fail;
        next_s.pf_s = s.pf_m;
        if (s.osc_stop || sec_tick) begin
            next_s.pre = '0;
        end else begin
            next_s.pre = s.pre + SEC_CNT_W'(1);
        end
        if (!s.osc_stop && s.ft) begin
            next_s.ftc = ft_wrap ? '0 : s.ftc + FT_CNT_W'(1);
            next_s.ft_tog = ft_wrap ? !s.ft_tog : s.ft_tog;
        end else begin
            next_s.ftc = '0;
            next_s.ft_tog = 1'b0;
        end
        if (sec_tick) begin
            next_s.cnt = bntr_advance(s.cnt);
        end
        if (!halted) begin
            next_s.user = s.cnt;
        end
        // host writes to the clock registers
        if (wr_commit && wa_clk) begin
            case (s.wa)
                ADDR_CTRL: begin
                    next_s.ctl_w = s.wd[CTRL_W_BIT];
                    next_s.ctl_r = s.wd[CTRL_R_BIT];
                end
                ADDR_SEC: begin
                    next_s.osc_stop = s.wd[SEC_OSC_BIT];
                    next_s.user.sec = s.wd & MASK_SEC;
                end
                ADDR_MIN: next_s.user.min = s.wd & MASK_MIN;
                ADDR_HOUR: next_s.user.hour = s.wd & MASK_HOUR;
                ADDR_DAY: begin
                    next_s.ft = s.wd[DAY_FT_BIT];
                    next_s.user.day = s.wd & MASK_DAY;
                end
                ADDR_DATE: next_s.user.date = s.wd & MASK_DATE;
                ADDR_MONTH: next_s.user.month = s.wd & MASK_MONTH;
                ADDR_YEAR: next_s.user.year = s.wd & MASK_YEAR;
                default: next_s.ctl_w = s.ctl_w;
            endcase
        end
        if (w_release) begin
            next_s.cnt = s.user;
            next_s.pre = '0;
        end
        // write cycle capture, committed at its end
        if (wr_act) begin
            next_s.wr_pend = 1'b1;
            next_s.wa = s.bus_s.addr;
            next_s.wd = s.bus_s.dq;
        end else begin
            next_s.wr_pend = 1'b0;
        end
        next_s.drive = rd_cond;
        next_s.rd = rd_mux;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s <= ST_RESET;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clk_en && wr_commit && !wa_clk) begin
            ram[s.wa] <= s.wd;
        end
    end

    // pin outputs, low enable while driving
    assign data_pins_out = s.rd;
    assign data_pins_oe_n = !s.drive;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence q_release;
        clk_en && w_release;
    endsequence

    sequence q_loaded;
        s.cnt == $past(s.user) && !s.ctl_w;
    endsequence

    property p_pf_quiet;
        clk_en && s.pf_s |=> data_pins_oe_n && !s.wr_pend;
    endproperty
    a_pf_quiet: assert property (p_pf_quiet) else $error("power fail access seen");

    property p_deselect;
        clk_en && s.bus_s.ce_n |=> data_pins_oe_n;
    endproperty
    a_deselect: assert property (p_deselect) else $error("pins driven deselected");

    property p_read_drive;
        clk_en && rd_cond |=> !data_pins_oe_n && data_pins_out == $past(rd_mux);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");

    property p_oe_high;
        clk_en && !s.bus_s.ce_n && s.bus_s.we_n && s.bus_s.oe_n |=> data_pins_oe_n;
    endproperty
    a_oe_high: assert property (p_oe_high) else $error("pins driven, oe high");

    property p_halt_hold;
        clk_en && halted && !wr_commit |=> $stable(s.user);
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halted buffer changed");

    property p_refresh;
        clk_en && !halted && !wr_commit |=> s.user == $past(s.cnt);
    endproperty
    a_refresh: assert property (p_refresh) else $error("buffer not refreshed");

    property p_load;
        q_release |=> q_loaded;
    endproperty
    a_load: assert property (p_load) else $error("counters not loaded");

    property p_tick;
        clk_en && sec_tick && !w_release |=> s.cnt != $past(s.cnt) && s.pre == '0;
    endproperty
    a_tick: assert property (p_tick) else $error("second tick lost");

    property p_range;
        s.cnt.sec <= SEC_MAX && s.cnt.min <= MIN_MAX && s.cnt.hour <= HOUR_MAX;
    endproperty
    a_range: assert property (p_range) else $error("counter out of bcd range");

    property p_stop;
        clk_en && s.osc_stop && !w_release |=> $stable(s.cnt) && s.pre == '0;
    endproperty
    a_stop: assert property (p_stop) else $error("tick while stopped");

    property p_ft;
        clk_en && s.ft && !s.osc_stop && ft_wrap |=> s.ft_tog != $past(s.ft_tog);
    endproperty
    a_ft: assert property (p_ft) else $error("test wave not toggled");

    property p_ft_idle;
        clk_en && (!s.ft || s.osc_stop) |=> !s.ft_tog;
    endproperty
    a_ft_idle: assert property (p_ft_idle) else $error("test wave runs while off");

    sequence q_midnight;
        clk_en && sec_tick && !w_release && s.cnt.hour == HOUR_MAX && s.cnt.min == MIN_MAX
            && s.cnt.sec == SEC_MAX;
    endsequence

    sequence q_feb28;
        s.cnt.month == 8'h02 && s.cnt.date == 8'h28;
    endsequence

    property p_day_roll;
        q_midnight |=> s.cnt.hour == BCD_ZERO && s.cnt.day != $past(s.cnt.day);
    endproperty
    a_day_roll: assert property (p_day_roll) else $error("midnight roll missed");

    property p_leap;
        q_midnight ##0 q_feb28 |=>
            s.cnt.date == (bntr_leap($past(s.cnt.year)) ? 8'h29 : BCD_ONE);
    endproperty
    a_leap: assert property (p_leap) else $error("february end wrong");

    property p_halt_set;
        clk_en && wr_commit && s.wa == ADDR_CTRL && s.wd[CTRL_R_BIT] |=> s.ctl_r;
    endproperty
    a_halt_set: assert property (p_halt_set) else $error("read halt not taken");

    property p_wr_ram;
        clk_en && wr_commit && !wa_clk |=> ram[$past(s.wa)] == $past(s.wd);
    endproperty
    a_wr_ram: assert property (p_wr_ram) else $error("ram byte not stored");

endmodule

// ===== tb/bntr_host.sv
// host-side bus master model driving the sram-style pins
`timescale 1ns/1ps
module bntr_host
    import bntr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [DATA_W-1:0] data_pins_out,
    input wire logic data_pins_oe_n,
    output bntr_bus_t bus,
    output logic rd_valid,
    output logic [8:0] rd_res
);
    // ****************************************
    // bus cycles, all started at a falling edge
    // ****************************************
    initial begin
        bus = BUS_IDLE;
        rd_valid = 1'b0;
        rd_res = '0;
    end

    // released pins: selects high, stale address and data inverted
    task automatic idle();
        bus.ce_n = 1'b1;
        bus.we_n = 1'b1;
        bus.oe_n = 1'b1;
        bus.addr = ~bus.addr;
        bus.dq = ~bus.dq;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic oe);
        bus = '{addr: a, ce_n: 1'b0, oe_n: oe, we_n: 1'b0, dq: d};
        repeat (4) @(negedge clk_sys);
        idle();
        repeat (4) @(negedge clk_sys);
    endtask

    // read cycle; result 9'h100 when the pins stay released
    task automatic rd(input logic [ADDR_W-1:0] a, input logic oe, input logic ce);
        bus = '{addr: a, ce_n: ce, oe_n: oe, we_n: 1'b1, dq: ~bus.dq};
        repeat (5) @(negedge clk_sys);
        rd_res = data_pins_oe_n ? 9'h100 : {1'b0, data_pins_out};
        rd_valid = 1'b1;
        @(negedge clk_sys);
        rd_valid = 1'b0;
        idle();
        repeat (3) @(negedge clk_sys);
    endtask
endmodule

// ===== tb/bntr_top_tb_top.sv
// self-checking bench for the timekeeping ram
`timescale 1ns/1ps
module bntr_top_tb_top;
    import bntr_pkg::*;

    logic clk_sys;
    logic clk_en;
    logic resetn;
    logic power_fail;
    bntr_bus_t bus;
    logic [DATA_W-1:0] data_pins_out;
    logic data_pins_oe_n;
    logic rd_valid;
    logic [8:0] rd_res;
    logic [8:0] exp_q[$];
    int err_total = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'h000140ED;
    logic [ADDR_W-1:0] ra[7];
    logic [DATA_W-1:0] rv[7];
    logic [7:0] tset[7] = '{8'h59, 8'h59, 8'h23, 8'h01, 8'h28, 8'h02, 8'h00};
    logic [7:0] texp[8] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h02, 8'h29, 8'h02, 8'h00};

    // ****************************************
    // design, host model, clock
    // ****************************************
    bntr_top #(.P_SEC_CYCLES(20), .P_FT_CYCLES(3)) uut (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clk_en(clk_en),
        .bus_in(bus),
        .power_fail(power_fail),
        .data_pins_out(data_pins_out),
        .data_pins_oe_n(data_pins_oe_n)
    );

    bntr_host host_m (
        .clk_sys(clk_sys),
        .data_pins_out(data_pins_out),
        .data_pins_oe_n(data_pins_oe_n),
        .bus(bus),
        .rd_valid(rd_valid),
        .rd_res(rd_res)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [8:0] seen, input logic [8:0] want);
        n_tests++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask

    // note the expected result, then run the read
    task automatic rdx(input logic [10:0] a, input logic oe, input logic ce, input logic [8:0] e);
        exp_q.push_back(e);
        host_m.rd(a, oe, ce);
    endtask

    task automatic wrap_up();
        if (exp_q.size() != 0) begin
            err_total++;
        end
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // result watcher: oldest note against each read result
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            chk(rd_res, (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF);
        end
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        power_fail = 1'b0;
        repeat (20) @(negedge clk_sys);
        resetn = 1'b1;
        @(negedge clk_sys);
        // random bytes, distinct addresses, top ram byte last
        for (int i = 0; i < 7; i++) begin
            seed = lfsr(seed);
            ra[i] = (i == 6) ? 11'h7F7 : {i[2:0], seed[7:0]};
            rv[i] = seed[15:8];
            host_m.wr(ra[i], rv[i], seed[16]);
        end
        for (int i = 0; i < 7; i++) begin
            rdx(ra[i], 1'b0, 1'b0, {1'b0, rv[i]});
        end
        rdx(ra[0], 1'b1, 1'b0, 9'h100);
        rdx(ra[0], 1'b0, 1'b1, 9'h100);
        // power fail blocks write and read
        power_fail = 1'b1;
        repeat (3) @(negedge clk_sys);
        host_m.wr(ra[0], ~rv[0], 1'b1);
        rdx(ra[0], 1'b0, 1'b0, 9'h100);
        power_fail = 1'b0;
        repeat (3) @(negedge clk_sys);
        rdx(ra[0], 1'b0, 1'b0, {1'b0, rv[0]});
        // set time under write halt, unused bits zero
        host_m.wr(ADDR_CTRL, 8'h80, 1'b1);
        for (int i = 0; i < 7; i++) begin
            host_m.wr(ADDR_SEC + 11'(i), tset[i], 1'b1);
        end
        // load counters, one second later leap day
        host_m.wr(ADDR_CTRL, 8'h00, 1'b1);
        repeat (18) @(negedge clk_sys);
        host_m.wr(ADDR_CTRL, 8'h40, 1'b1);
        for (int i = 0; i < 8; i++) begin
            rdx(ADDR_CTRL + 11'(i), 1'b0, 1'b0, {1'b0, texp[i]});
        end
        // release halt, four seconds have run meanwhile
        host_m.wr(ADDR_CTRL, 8'h00, 1'b1);
        rdx(ADDR_SEC, 1'b0, 1'b0, 9'h004);
        // stop the timebase mid-second, seconds stay at 05
        repeat (10) @(negedge clk_sys);
        host_m.wr(ADDR_SEC, 8'h80, 1'b1);
        repeat (40) @(negedge clk_sys);
        rdx(ADDR_SEC, 1'b0, 1'b0, 9'h085);
        // test bit while stopped: wave idles low
        host_m.wr(ADDR_DAY, 8'h42, 1'b1);
        rdx(ADDR_SEC, 1'b0, 1'b0, 9'h084);
        rdx(ADDR_DAY, 1'b0, 1'b0, 9'h042);
        // restart, test bit off, one more second counted
        host_m.wr(ADDR_SEC, 8'h00, 1'b1);
        host_m.wr(ADDR_DAY, 8'h02, 1'b1);
        repeat (20) @(negedge clk_sys);
        rdx(ADDR_SEC, 1'b0, 1'b0, 9'h006);
        // clock enable low freezes the count for 40 cycles
        clk_en = 1'b0;
        repeat (40) @(negedge clk_sys);
        clk_en = 1'b1;
        repeat (10) @(negedge clk_sys);
        rdx(ADDR_SEC, 1'b0, 1'b0, 9'h007);
        wrap_up();
    end
endmodule
